/* File: src/encoder_extended_diagnosis.sv */
// Notes on behaviour
// - Byte 8: five alarm flags, bits 5-7 zero
// - Byte 9: direction and class-2/diagnosis/scaling support
// - Byte 10: 00 single-turn, 01 multi-turn
// - Bytes 11-14: hardware single-turn resolution
// - Bytes 15-16: revolutions, single-turn 1, overflow 0
// - Byte 17 reserved, reads all zero
// - Bytes 20-21: five warning flags
// - Bytes 22-23: supported warnings, bits 5-15 zero
// - Bytes 24-25: profile version number then index
// - Bytes 26-27: firmware version, same coding
// - Bytes 28-31: hour counter, one per 6 minutes
// - Counter reads FFFFFFF when hours unsupported
// - Telegram after parameterization or error report
// - Hour counter change alone sends no telegram
// - Bytes 32-35: preset offset
// - Bytes 36-39: maker offset from preset
// - Bytes 40-43: configured increments per revolution
// - Bytes 44-47: configured measuring length
// - Bytes 48-57: ten-byte serial number, nothing beyond
// - Internal error sets ext-diag and static-diag flags
// - Flags block position data, bus clears them only by clearing diag enable
// - Error flagging only with commissioning diagnostics on
// - Byte 7 holds length of bytes 7-57, itself included
// - Ext-diag byte 1 bit 3, static byte 2 bit 1
`include "diag_map.svh"
module encoder_extended_diagnosis #(
  parameter longint unsigned TICK_CYCLES =
    longint'(`HOUR_TICK_MIN) * longint'(`SEC_PER_MIN) * longint'(`CLK_HZ),
  parameter logic [15:0] FW_VERSION = `FW_VERSION_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [4:0] alarm_in,
  input wire logic [4:0] warn_in,
  input wire diag_pkg::byte_index_t rd_byte_addr,
  output diag_pkg::diag_byte_t rd_byte_data,
  output logic telegram_q,
  output diag_pkg::diag_byte_t std_byte1_q,
  output diag_pkg::diag_byte_t std_byte2_q,
  output logic position_enable_q
);
  import diag_pkg::*;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 64'h3_FFFF_FFFF) begin : g_tick_check
    $error("TICK_CYCLES out of range");
  end

  diag_mem_if mem ();
  diag_msg_ram #(.DEPTH(64)) u_ram (.hclk(hclk), .ce(ce), .mem(mem));

  logic [7:0] ctrl_q;
  logic [31:0] resolution_q, revs_q, offset_q, mfr_offset_q, ipr_q, mlen_q;
  logic [31:0] serial0_q, serial1_q, support_q;
  logic [15:0] serial2_q;
  logic [31:0] hours_q;
  logic [33:0] tick_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic param_pulse_q;
  logic err_flag_q;
  logic [4:0] alarm_seen_q;
  logic trig_pend_q;
  fill_state_e state_q;
  byte_index_t idx_q;

  logic addr_ok;
  logic diag_en;
  logic err_now;
  logic err_event;
  logic [31:0] rd_mux;
  logic [15:0] revs_field;
  logic [31:0] hours_field;
  logic [7:0] status_byte;
  logic [8*`MSG_BYTES-1:0] msg;

  assign addr_ok = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
  assign diag_en = ctrl_q[`CTRL_DIAG_EN];
  assign err_now = diag_en && (|alarm_in);
  assign err_event = diag_en && (alarm_in != alarm_seen_q);

  // Register read mux
  always_comb begin
    unique case (haddr[7:0])
      `REG_CTRL: rd_mux = {24'h000000, ctrl_q};
      `REG_STATUS: rd_mux = {16'h0000, 3'h0, warn_in, 1'b0, err_flag_q, 1'b0, alarm_in};
      `REG_RESOLUTION: rd_mux = resolution_q;
      `REG_REVS: rd_mux = revs_q;
      `REG_VERSION: rd_mux = {`PROFILE_VERSION, FW_VERSION};
      `REG_OFFSET: rd_mux = offset_q;
      `REG_MFR_OFFSET: rd_mux = mfr_offset_q;
      `REG_INC_PER_REV: rd_mux = ipr_q;
      `REG_MEAS_LEN: rd_mux = mlen_q;
      `REG_SERIAL0: rd_mux = serial0_q;
      `REG_SERIAL1: rd_mux = serial1_q;
      `REG_SERIAL2: rd_mux = {16'h0000, serial2_q};
      `REG_HOURS: rd_mux = hours_field;
      `REG_SUPPORT: rd_mux = support_q;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Bus handshake, zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Register writes; error flags are not reachable from the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `CTRL_RESET;
      resolution_q <= 32'h00000000;
      revs_q <= 32'h00000000;
      offset_q <= 32'h00000000;
      mfr_offset_q <= 32'h00000000;
      ipr_q <= 32'h00000000;
      mlen_q <= 32'h00000000;
      serial0_q <= 32'h00000000;
      serial1_q <= 32'h00000000;
      serial2_q <= 16'h0000;
      support_q <= `SUPPORT_RESET;
      param_pulse_q <= 1'b0;
    end else if (ce) begin
      param_pulse_q <= 1'b0;
      if (wr_pend_q) begin
        unique case (wr_addr_q)
          `REG_CTRL: begin
            ctrl_q <= {hwdata[7:5], 1'b0, hwdata[3:0]};
            param_pulse_q <= hwdata[`CTRL_PARAM_DONE];
          end
          `REG_RESOLUTION: resolution_q <= hwdata;
          `REG_REVS: revs_q <= hwdata;
          `REG_OFFSET: offset_q <= hwdata;
          `REG_MFR_OFFSET: mfr_offset_q <= hwdata;
          `REG_INC_PER_REV: ipr_q <= hwdata;
          `REG_MEAS_LEN: mlen_q <= hwdata;
          `REG_SERIAL0: serial0_q <= hwdata;
          `REG_SERIAL1: serial1_q <= hwdata;
          `REG_SERIAL2: serial2_q <= hwdata[15:0];
          `REG_SUPPORT: support_q <= {19'h00000, hwdata[12:8], 3'h0, hwdata[4:0]};
          default: ;
        endcase
      end
    end
  end

  // Operating hour counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 34'h000000000;
      hours_q <= 32'h00000000;
    end else if (ce) begin
      if (tick_q == 34'(TICK_CYCLES - 1)) begin
        tick_q <= 34'h000000000;
        hours_q <= hours_q + 32'h00000001;
      end else begin
        tick_q <= tick_q + 34'h000000001;
      end
    end
  end

  // Error flags follow the alarm state, cleared when alarms go or diagnostics are off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_flag_q <= 1'b0;
      std_byte1_q <= 8'h00;
      std_byte2_q <= 8'h00;
      position_enable_q <= 1'b1;
      alarm_seen_q <= 5'h00;
    end else if (ce) begin
      err_flag_q <= err_now;
      std_byte1_q <= 8'(err_now) << `STD1_EXT_DIAG;
      std_byte2_q <= 8'(err_now) << `STD2_STAT_DIAG;
      position_enable_q <= !err_now;
      if (diag_en) begin
        alarm_seen_q <= alarm_in;
      end
    end
  end

  // Message fields
  assign revs_field = !ctrl_q[`CTRL_MULTI] ? `REVS_SINGLE :
    (revs_q > `REVS_LIMIT) ? `REVS_TOO_BIG : revs_q[15:0];
  assign hours_field = ctrl_q[`CTRL_HOURS_EN] ? hours_q : `HOURS_UNSUP;
  assign status_byte = {4'h0, ctrl_q[`CTRL_SCALE_SUP], ctrl_q[`CTRL_DIAG_SUP],
    ctrl_q[`CTRL_CLASS2], ctrl_q[`CTRL_CCW]};
  assign msg = {
    `EXT_LEN,
    {3'h0, alarm_in},
    status_byte,
    ctrl_q[`CTRL_MULTI] ? `TYPE_MULTI : `TYPE_SINGLE,
    resolution_q,
    revs_field,
    8'h00,
    {11'h000, support_q[`SUP_AL_LSB +: 5]},
    {11'h000, warn_in},
    {11'h000, support_q[`SUP_WR_LSB +: 5]},
    `PROFILE_VERSION,
    FW_VERSION,
    hours_field,
    offset_q,
    mfr_offset_q,
    ipr_q,
    mlen_q,
    serial0_q, serial1_q, serial2_q
  };

  // Telegram request, a new request during a fill is held and served after it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_pend_q <= 1'b0;
    end else if (ce) begin
      if (param_pulse_q || err_event) begin
        trig_pend_q <= 1'b1;
      end else if (state_q == ST_IDLE) begin
        trig_pend_q <= 1'b0;
      end
    end
  end

  // Snapshot of bytes 7 to 57 into the message store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      idx_q <= `FIRST_BYTE;
      telegram_q <= 1'b0;
    end else if (ce) begin
      telegram_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          idx_q <= `FIRST_BYTE;
          if (trig_pend_q) begin
            state_q <= ST_FILL;
          end
        end
        ST_FILL: begin
          if (idx_q == `LAST_BYTE) begin
            state_q <= ST_DONE;
          end else begin
            idx_q <= idx_q + 6'd1;
          end
        end
        ST_DONE: begin
          telegram_q <= 1'b1;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign mem.we = (state_q == ST_FILL);
  assign mem.waddr = idx_q;
  assign mem.wdata = msg[8 * (`MSG_BYTES - 1 - int'(idx_q - `FIRST_BYTE)) +: 8];
  assign mem.raddr = rd_byte_addr;
  assign rd_byte_data = mem.rdata;

  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp) else $error("bus not ready or not okay");
  a_flags_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && diag_en && (|alarm_in) |=> std_byte1_q[`STD1_EXT_DIAG] && std_byte2_q[`STD2_STAT_DIAG])
    else $error("error flags not set");
  a_position_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
    std_byte2_q[`STD2_STAT_DIAG] |-> !position_enable_q)
    else $error("position data while flagged");
  a_diag_off_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !diag_en |=> !err_flag_q) else $error("flag set with diagnostics off");
  a_param_telegram: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && param_pulse_q |-> ##[1:120] telegram_q) else $error("no telegram after parameters");
  a_hours_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_IDLE && !trig_pend_q |=> !telegram_q) else $error("unrequested telegram");
  a_hours_unsup: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_q[`CTRL_HOURS_EN] |-> hours_field == `HOURS_UNSUP) else $error("bad hours value");
  a_single_revs: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_q[`CTRL_MULTI] |-> revs_field == `REVS_SINGLE) else $error("single-turn revs");
  a_len_byte: assert property (@(posedge hclk) disable iff (!hresetn)
    mem.we && mem.waddr == `FIRST_BYTE |-> mem.wdata == `EXT_LEN) else $error("length byte");
  a_fill_span: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && state_q == ST_IDLE && trig_pend_q |=> mem.we ##50 (mem.waddr == `LAST_BYTE))
    else $error("fill span wrong");
endmodule

/* File: src/diag_map.svh */
`ifndef DIAG_MAP_SVH
`define DIAG_MAP_SVH
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RESOLUTION 8'h08
`define REG_REVS 8'h0C
`define REG_VERSION 8'h10
`define REG_OFFSET 8'h14
`define REG_MFR_OFFSET 8'h18
`define REG_INC_PER_REV 8'h1C
`define REG_MEAS_LEN 8'h20
`define REG_SERIAL0 8'h24
`define REG_SERIAL1 8'h28
`define REG_SERIAL2 8'h2C
`define REG_HOURS 8'h30
`define REG_SUPPORT 8'h34
`define CTRL_CCW 0
`define CTRL_MULTI 1
`define CTRL_HOURS_EN 2
`define CTRL_DIAG_EN 3
`define CTRL_PARAM_DONE 4
`define CTRL_CLASS2 5
`define CTRL_DIAG_SUP 6
`define CTRL_SCALE_SUP 7
`define CTRL_RESET 8'h0E
`define SUP_AL_LSB 0
`define SUP_WR_LSB 8
`define SUPPORT_RESET 32'h00001F1F
`define PROFILE_VERSION 16'h0140
`define FW_VERSION_DEF 16'h0100
`define TYPE_SINGLE 8'h00
`define TYPE_MULTI 8'h01
`define REVS_SINGLE 16'h0001
`define REVS_LIMIT 32'h0000FFFF
`define REVS_TOO_BIG 16'h0000
`define HOURS_UNSUP 32'h0FFFFFFF
`define EXT_LEN 8'h33
`define FIRST_BYTE 6'd7
`define LAST_BYTE 6'd57
`define MSG_BYTES 51
`define STD1_EXT_DIAG 3
`define STD2_STAT_DIAG 1
`define HOUR_TICK_MIN 6
`define SEC_PER_MIN 60
`define CLK_HZ 20000000
`define HTRANS_NONSEQ_BIT 1
`endif

/* File: src/diag_pkg.sv */
package diag_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_DONE} fill_state_e;
  typedef logic [7:0] diag_byte_t;
  typedef logic [5:0] byte_index_t;
endpackage

/* File: src/diag_mem_if.sv */
interface diag_mem_if;
  logic we;
  diag_pkg::byte_index_t waddr;
  diag_pkg::diag_byte_t wdata;
  diag_pkg::byte_index_t raddr;
  diag_pkg::diag_byte_t rdata;
  modport writer (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* File: src/diag_msg_ram.sv */
module diag_msg_ram #(
  parameter int DEPTH = 64
) (
  input wire logic hclk,
  input wire logic ce,
  diag_mem_if.store mem
);
  import diag_pkg::*;
  diag_byte_t ram_q [DEPTH];
  diag_byte_t rdata_q;
  if (DEPTH < 58 || DEPTH > 64) begin : g_depth_check
    $error("DEPTH must hold bytes 7 to 57");
  end
  always_ff @(posedge hclk) begin
    if (ce && mem.we) begin
      ram_q[mem.waddr] <= mem.wdata;
    end
  end
  always_ff @(posedge hclk) begin
    if (ce) begin
      rdata_q <= ram_q[mem.raddr];
    end
  end
  assign mem.rdata = rdata_q;
endmodule

/* File: testbench/diag_reader.sv */
module diag_reader (
  input wire logic hclk,
  input wire logic telegram_q,
  input wire diag_pkg::diag_byte_t rd_byte_data,
  input wire diag_pkg::diag_byte_t std_byte2_q,
  output diag_pkg::byte_index_t rd_byte_addr,
  output logic excluded,
  output int frames,
  output int pulses,
  output diag_pkg::diag_byte_t msg [7:57]
);
  timeunit 1ns;
  timeprecision 1ps;
  import diag_pkg::*;
  // Station out of the process image while static flag is set
  assign excluded = std_byte2_q[1];
  always @(posedge hclk) begin
    if (telegram_q === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  // Reads the whole message after each telegram that arrives while no read is running
  initial begin
    rd_byte_addr = 6'h07;
    frames = 0;
    forever begin
      @(posedge hclk);
      if (telegram_q === 1'b1) begin
        for (int i = 7; i <= 57; i++) begin
          rd_byte_addr <= 6'(i);
          repeat (2) @(posedge hclk);
          msg[i] = rd_byte_data;
        end
        frames = frames + 1;
      end
    end
  end
endmodule

/* File: testbench/encoder_extended_diagnosis_test.sv */
`include "diag_map.svh"
module encoder_extended_diagnosis_test;
  timeunit 1ns;
  timeprecision 1ps;
  import diag_pkg::*;
  logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, telegram_q, position_enable_q, excluded;
  logic [31:0] haddr, hwdata, hrdata, seed, r, h1, h2;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] alarm_in, warn_in;
  byte_index_t rd_byte_addr;
  diag_byte_t rd_byte_data, std_byte1_q, std_byte2_q;
  diag_byte_t msg [7:57];
  diag_byte_t e [7:57];
  logic [31:0] m [0:15];
  int frames, pulses, miscompares, check_count, p;
  int idx [10] = '{2, 3, 5, 6, 7, 8, 9, 10, 11, 13};

  encoder_extended_diagnosis #(.TICK_CYCLES(20)) u_encoder_extended_diagnosis (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .alarm_in(alarm_in),
    .warn_in(warn_in), .rd_byte_addr(rd_byte_addr), .rd_byte_data(rd_byte_data),
    .telegram_q(telegram_q), .std_byte1_q(std_byte1_q), .std_byte2_q(std_byte2_q),
    .position_enable_q(position_enable_q)
  );
  diag_reader u_diag_reader (
    .hclk(hclk), .telegram_q(telegram_q), .rd_byte_data(rd_byte_data),
    .std_byte2_q(std_byte2_q), .rd_byte_addr(rd_byte_addr), .excluded(excluded),
    .frames(frames), .pulses(pulses), .msg(msg)
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask

  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    m[a[5:2]] = (a == 32'h0) ? (d & 32'hEF) : d;
    ahb(1'b1, a, d, rd);
  endtask

  task automatic rreg(input logic [31:0] a, output logic [31:0] rd);
    ahb(1'b0, a, 32'h0, rd);
  endtask

  function automatic void put32(input int i, input logic [31:0] v);
    e[i] = v[31:24];
    e[i + 1] = v[23:16];
    e[i + 2] = v[15:8];
    e[i + 3] = v[7:0];
  endfunction

  task automatic compare();
    logic [31:0] rv;
    rv = m[0][1] ? ((m[3] > 32'hFFFF) ? 32'h0 : m[3]) : 32'h1;
    e[7] = 8'h33;
    e[8] = {3'h0, alarm_in};
    e[9] = {4'h0, m[0][7:5], m[0][0]};
    e[10] = {7'h0, m[0][1]};
    put32(11, m[2]);
    e[15] = rv[15:8];
    e[16] = rv[7:0];
    e[17] = 8'h00;
    put32(18, {11'h0, m[13][4:0], 11'h0, warn_in});
    put32(22, {11'h0, m[13][12:8], 16'h0140});
    e[26] = `FW_VERSION_DEF >> 8;
    e[27] = `FW_VERSION_DEF & 8'hFF;
    put32(28, 32'h0FFFFFFF);
    for (int k = 0; k < 6; k++) put32(32 + 4 * k, m[5 + k]);
    e[56] = m[11][15:8];
    e[57] = m[11][7:0];
    for (int i = 7; i <= 57; i++) begin
      if (!(m[0][2] && i >= 28 && i <= 31)) check(32'(msg[i]), 32'(e[i]));
    end
  endtask

  task automatic wait_frame();
    int f, k;
    f = frames;
    k = 0;
    while (frames == f && k < 300) begin
      @(posedge hclk);
      k++;
    end
    check(32'(frames - f), 32'h1);
  endtask

  task automatic snap();
    wreg(32'h0, m[0] | 32'h10);
    wait_frame();
    compare();
  endtask

  task automatic flags(input logic set);
    check(32'(std_byte1_q), set ? 32'h08 : 32'h0);
    check(32'(std_byte2_q), set ? 32'h02 : 32'h0);
    check(32'(position_enable_q), 32'(!set));
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    test_done();
  end

  initial begin
    {hsel, htrans, hwrite, haddr, hwdata, alarm_in, warn_in, hresetn} = '0;
    hsize = 3'h2;
    ce = 1'b1;
    seed = 32'h33;
    for (int k = 0; k < 16; k++) m[k] = 32'h0;
    m[0] = 32'h0E;
    m[13] = 32'h1F1F;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    flags(1'b0);
    rreg(32'h34, r);
    check(r, 32'h1F1F);
    ahb(1'b1, 32'h10, rnd(), r);
    rreg(32'h10, r);
    check(r, {16'h0140, `FW_VERSION_DEF});
    ahb(1'b1, 32'h40, rnd(), r);
    rreg(32'h40, r);
    check(r, 32'h0);
    foreach (idx[k]) wreg(32'(idx[k] * 4), rnd());
    for (int c = 0; c < 3; c++) begin
      r = rnd();
      warn_in <= r[20:16];
      wreg(32'h0C, (c == 0) ? r : ((c == 1) ? 32'h10000 : 32'hFFFF));
      wreg(32'h0, {24'h0, r[7:5], 3'h2, 1'(c != 0), r[0]});
      snap();
    end
    wreg(32'h0, 32'h0E);
    p = pulses;
    rreg(32'h30, h1);
    repeat (200) @(posedge hclk);
    rreg(32'h30, h2);
    check(32'((h2 - h1) inside {32'hA, 32'hB}), 32'h1);
    check(32'(pulses), 32'(p));
    r = rnd();
    alarm_in <= r[4:0] | 5'h01;
    wait_frame();
    compare();
    flags(1'b1);
    check(32'(excluded), 32'h1);
    rreg(32'h04, r);
    check(r, {16'h0, 3'h0, warn_in, 3'h2, alarm_in});
    snap();
    flags(1'b1);
    alarm_in <= 5'h00;
    wait_frame();
    compare();
    flags(1'b0);
    wreg(32'h0, 32'h06);
    alarm_in <= 5'h04;
    repeat (10) @(posedge hclk);
    flags(1'b0);
    test_done();
  end
endmodule
